// ===== rtl/celq_top.sv
// Overview of operation
// - register qualifies only entries 24 to 31
// - masks apply only when qualify enable set
// - entry 24 at top nibble, descending
// - top bit enables port 0 reception
// - bit 2 enables port 0-to-1 relay
// - bit 1 enables port 1 reception
// - bottom bit enables port 1-to-0 relay
// - bits are independent context enables
// - entry address 48 bits, upper plus lower
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module celq_top
  import celq_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
  output logic [DATA_W-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // lookup request
  input wire logic I_LKP_REQ,
  input wire logic [1:0] I_LKP_CTX,
  input wire logic [MAC_W-1:0] I_LKP_DA,
  // lookup answer
  output logic O_LKP_DONE,
  output logic O_LKP_HIT,
  output logic [NUM_ENTRIES-1:0] O_LKP_HIT_VEC
);
  logic ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] cond_mask_ff;
  logic qualify_en_ff;
  logic busy_ff;
  logic [1:0] busy_cnt_ff;
  logic [UPPER_W-1:0] ent_upper [NUM_ENTRIES];
  logic [LOWER_W-1:0] ent_lower [NUM_ENTRIES];
  logic done_ff;
  logic hit_ff;
  logic [NUM_ENTRIES-1:0] hit_vec_ff;
  logic [NUM_ENTRIES-1:0] match;
  logic req;
  logic wr_go;
  logic wr_mask;
  logic wr_fwd;
  logic wr_upper;
  logic wr_lower;
  logic in_entry;
  logic is_lower;
  logic [IDX_W-1:0] ent_idx;

  // bus request decode
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr_go = I_AVS_WRITE & ack_ff;
  assign in_entry = (I_AVS_ADDRESS >= OFS_ENTRY_BASE) && (I_AVS_ADDRESS <= OFS_ENTRY_LAST);
  assign ent_idx = I_AVS_ADDRESS[ENTRY_SEL_LSB +: IDX_W];
  assign is_lower = I_AVS_ADDRESS[LOWER_SEL_BIT];

  // one write strobe per register group, all on the completing edge
  assign wr_mask = wr_go && (I_AVS_ADDRESS == OFS_COND_MASK);
  assign wr_fwd = wr_go && (I_AVS_ADDRESS == OFS_FWD_SELECT);
  assign wr_upper = wr_go && in_entry && !is_lower;
  assign wr_lower = wr_go && in_entry && is_lower;

  // one wait state on every access
  assign O_AVS_WAITREQUEST = req & ~ack_ff;
  assign O_AVS_READDATA = rdata_ff;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    nxt_rdata = RST_ZERO;
    if (I_AVS_ADDRESS == OFS_COND_MASK) begin
      nxt_rdata = cond_mask_ff;
    end else if (I_AVS_ADDRESS == OFS_FWD_SELECT) begin
      nxt_rdata[QUALIFY_EN_BIT] = qualify_en_ff;
    end else if (I_AVS_ADDRESS == OFS_BUSY) begin
      nxt_rdata[BUSY_BIT] = busy_ff;
    end else if (in_entry && is_lower) begin
      nxt_rdata[LOWER_W-1:0] = ent_lower[ent_idx];
    end else if (in_entry) begin
      nxt_rdata = ent_upper[ent_idx];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      rdata_ff <= RST_ZERO;
    end else if (I_AVS_READ && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // condition mask register, entries 24..31 only
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cond_mask_ff <= RST_COND_MASK;
    end else if (wr_mask) begin
      cond_mask_ff <= I_AVS_WRITEDATA;
    end
  end

  // forwarding select control, qualify enable bit
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      qualify_en_ff <= 1'b0;
    end else if (wr_fwd) begin
      qualify_en_ff <= I_AVS_WRITEDATA[QUALIFY_EN_BIT];
    end
  end

  // commit countdown started by each lower write
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      busy_cnt_ff <= 2'h0;
    end else if (wr_lower) begin
      busy_cnt_ff <= COMMIT_CYCLES;
    end else if (busy_cnt_ff != 2'h0) begin
      busy_cnt_ff <= busy_cnt_ff - 2'h1;
    end
  end

  // table busy while the commit runs; a new lower write restarts it
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      busy_ff <= 1'b0;
    end else if (wr_lower) begin
      busy_ff <= 1'b1;
    end else if (busy_cnt_ff != 2'h0) begin
      busy_ff <= (busy_cnt_ff != 2'h1);
    end
  end

  // per-entry address storage, qualification and compare
  generate
    for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
      logic [UPPER_W-1:0] upper_ff;
      logic [LOWER_W-1:0] lower_ff;
      logic valid_ff;
      logic addr_sel;

      // this entry is the one the bus address points at
      assign addr_sel = (ent_idx == IDX_W'(g));

      // upper part of the station address
      always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
          upper_ff <= RST_ZERO[UPPER_W-1:0];
        end else if (wr_upper && addr_sel) begin
          upper_ff <= I_AVS_WRITEDATA[UPPER_W-1:0];
        end
      end

      // lower part; reserved upper bits of the word are not kept
      always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
          lower_ff <= RST_ZERO[LOWER_W-1:0];
        end else if (wr_lower && addr_sel) begin
          lower_ff <= I_AVS_WRITEDATA[LOWER_W-1:0];
        end
      end

      // entry joins lookups once its lower part has landed
      always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
          valid_ff <= 1'b0;
        end else if (wr_lower && addr_sel) begin
          valid_ff <= 1'b1;
        end
      end

      // copies for the read mux
      assign ent_upper[g] = upper_ff;
      assign ent_lower[g] = lower_ff;

      // field of entry 24+g sits four bits lower per step
      celq_entry_match u_match (
        .i_field(cond_mask_ff[DATA_W-1-g*FIELD_W -: FIELD_W]),
        .i_addr({upper_ff, lower_ff}),
        .i_valid(valid_ff),
        .i_qualify_en(qualify_en_ff),
        .i_ctx(I_LKP_CTX),
        .i_da(I_LKP_DA),
        .o_match(match[g])
      );
    end
  endgenerate

  // registered lookup answer one cycle after request
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      done_ff <= 1'b0;
      hit_vec_ff <= '0;
    end else begin
      done_ff <= I_LKP_REQ;
      if (I_LKP_REQ) begin
        hit_vec_ff <= match;
      end
    end
  end

  // summary hit flag, registered beside the vector
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      hit_ff <= 1'b0;
    end else if (I_LKP_REQ) begin
      hit_ff <= |match;
    end
  end

  assign O_LKP_DONE = done_ff;
  assign O_LKP_HIT_VEC = hit_vec_ff;
  assign O_LKP_HIT = hit_ff;
endmodule // celq_top
`default_nettype wire

// ===== rtl/celq_pkg.sv
package celq_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // table slice handled here
  localparam int FIRST_ENTRY = 24;
  localparam int LAST_ENTRY = 31;
  localparam int NUM_ENTRIES = LAST_ENTRY - FIRST_ENTRY + 1;
  localparam int FIELD_W = 4;
  localparam int MAC_W = 48;
  localparam int UPPER_W = 32;
  localparam int LOWER_W = 16;
  localparam int IDX_W = 3;
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_COND_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FWD_SELECT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BUSY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_LAST = 8'h7c;
  // field positions
  localparam int QUALIFY_EN_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int ENTRY_SEL_LSB = 3;
  localparam int LOWER_SEL_BIT = 2;
  // field bits within one entry nibble
  localparam int FLD_P0_RX = 3;
  localparam int FLD_RELAY_0_1 = 2;
  localparam int FLD_P1_RX = 1;
  localparam int FLD_RELAY_1_0 = 0;
  // reset values
  localparam logic [DATA_W-1:0] RST_COND_MASK = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
  // busy time of one table commit, in cycles
  localparam logic [1:0] COMMIT_CYCLES = 2'h2;
  // lookup contexts
  typedef enum logic [1:0] {
    CTX_P0_RX,
    CTX_RELAY_0_1,
    CTX_P1_RX,
    CTX_RELAY_1_0
  } celq_ctx_e;
endpackage

// ===== rtl/celq_entry_match.sv
`timescale 1ns/10ps
`default_nettype none
module celq_entry_match
  import celq_pkg::*;
(
  // entry contents
  input wire logic [FIELD_W-1:0] i_field,
  input wire logic [MAC_W-1:0] i_addr,
  input wire logic i_valid,
  // qualify enable and lookup request
  input wire logic i_qualify_en,
  input wire logic [1:0] i_ctx,
  input wire logic [MAC_W-1:0] i_da,
  // result
  output logic o_match
);
  logic consulted;

  // pick the enable bit for the context; bits act independently
  always_comb begin
    if (!i_qualify_en) begin
      consulted = 1'b1;
    end else begin
      case (celq_ctx_e'(i_ctx))
        CTX_P0_RX: consulted = i_field[FLD_P0_RX];
        CTX_RELAY_0_1: consulted = i_field[FLD_RELAY_0_1];
        CTX_P1_RX: consulted = i_field[FLD_P1_RX];
        default: consulted = i_field[FLD_RELAY_1_0];
      endcase
    end
  end

  // with qualify enable set, an all-zero field leaves consulted low in every context
  assign o_match = consulted & i_valid & (i_addr == i_da);
endmodule // celq_entry_match
`default_nettype wire

// ===== test/celq_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module celq_chk
  import celq_pkg::*;
(
  // watched ports
  input wire logic I_REF_CLK, I_RST, I_AVS_READ, I_AVS_WRITE, I_LKP_REQ,
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic [DATA_W-1:0] I_AVS_WRITEDATA, O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST, O_LKP_DONE, O_LKP_HIT,
  input wire logic [1:0] I_LKP_CTX,
  input wire logic [MAC_W-1:0] I_LKP_DA,
  input wire logic [NUM_ENTRIES-1:0] O_LKP_HIT_VEC
);
  logic [DATA_W-1:0] mask_ff;
  logic qen_ff;
  logic [7:0] sel;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // shadow of mask and enable writes
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mask_ff <= '0;
      qen_ff <= 1'b0;
    end else if (I_AVS_WRITE && !O_AVS_WAITREQUEST) begin
      if (I_AVS_ADDRESS == OFS_COND_MASK) mask_ff <= I_AVS_WRITEDATA;
      if (I_AVS_ADDRESS == OFS_FWD_SELECT) qen_ff <= I_AVS_WRITEDATA[QUALIFY_EN_BIT];
    end
  end
  // field bit of each entry for the asked context
  always_comb for (int k = 0; k < 8; k++) sel[k] = mask_ff[4*(7-k)+3-int'(I_LKP_CTX)];
  property p_done; I_LKP_REQ |=> O_LKP_DONE; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_nodone; !I_LKP_REQ |=> !O_LKP_DONE; endproperty
  a_nodone: assert property (p_nodone) else $error("stray done");
  property p_hit; O_LKP_HIT == |O_LKP_HIT_VEC; endproperty
  a_hit: assert property (p_hit) else $error("hit not or of vector");
  property p_hold; !I_LKP_REQ |=> $stable(O_LKP_HIT_VEC); endproperty
  a_hold: assert property (p_hold) else $error("vector moved");
  property p_wait; $rose(I_AVS_READ | I_AVS_WRITE) |-> O_AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_one; O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
  a_one: assert property (p_one) else $error("wait too long");
  property p_idle; !(I_AVS_READ | I_AVS_WRITE) |-> !O_AVS_WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_qual; I_LKP_REQ && qen_ff |=> (O_LKP_HIT_VEC & ~$past(sel)) == 0; endproperty
  a_qual: assert property (p_qual) else $error("unqualified hit");
  c_qual: cover property (I_LKP_REQ && qen_ff);
  c_hit: cover property (O_LKP_HIT);
  c_wr: cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
endmodule // celq_chk
bind celq_top celq_chk u_chk (.*);
`default_nettype wire

// ===== test/celq_lkp_src.sv
`timescale 1ns/10ps
`default_nettype none
module celq_lkp_src (
  // clock
  input wire logic i_clk,
  // lookup request
  output logic o_req,
  output logic [1:0] o_ctx,
  output logic [47:0] o_da
);
  initial begin
    o_req = 1'h0;
    o_ctx = 2'h0;
    o_da = 48'h0;
  end
  // one-cycle strobe, address scrambled once it is gone
  task automatic look(input logic [1:0] c, input logic [47:0] d);
    @(posedge i_clk);
    o_req <= 1'h1;
    o_ctx <= c;
    o_da <= d;
    @(posedge i_clk);
    o_req <= 1'h0;
    o_da <= ~d;
  endtask
endmodule // celq_lkp_src
`default_nettype wire

// ===== test/test_celq_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_celq_top
  import celq_pkg::*;
;
  logic clk, rst, rd, wr, req, done, hit, wq;
  logic [1:0] ctx;
  logic [7:0] adr, vec;
  logic [31:0] wd, rdat, m, e;
  logic [47:0] da, base;
  logic [31:0] q[$];
  int n_errors, n_checks, seed = 19485;
  celq_top u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq),
    .I_LKP_REQ(req), .I_LKP_CTX(ctx), .I_LKP_DA(da), .O_LKP_DONE(done), .O_LKP_HIT(hit),
    .O_LKP_HIT_VEC(vec));
  celq_lkp_src u_src (.i_clk(clk), .o_req(req), .o_ctx(ctx), .o_da(da));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // bus cycle held until waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    rd <= 0;
    wr <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] v);
    logic [31:0] e;
    e = q.pop_front();
    n_checks++;
    if (v !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic report_and_stop;
    // notes never answered count as one mismatch in all
    if (q.size() != 0) n_errors++;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // oldest note against each result
  always @(posedge clk) begin
    if (rd && wq === 1'b0) chk("readdata", rdat);
    if (done === 1'b1) chk("hit_vec", {23'h0, hit, vec});
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    q.push_back(0);
    bus(0, OFS_COND_MASK, 0);
    q.push_back(0);
    bus(0, 8'h20, 0);
    base = {$random(seed), 16'h0};
    // upper then lower, busy seen high then low before the next entry
    for (int k = 0; k < 8; k++) begin
      bus(1, 8'(OFS_ENTRY_BASE + 8*k), base[47:16]);
      bus(1, 8'(OFS_ENTRY_BASE + 8*k + 4), k);
      q.push_back(1);
      bus(0, OFS_BUSY, 0);
      q.push_back(0);
      bus(0, OFS_BUSY, 0);
      q.push_back(base[47:16]);
      bus(0, 8'(OFS_ENTRY_BASE + 8*k), 0);
      q.push_back(k);
      bus(0, 8'(OFS_ENTRY_BASE + 8*k + 4), 0);
    end
    // pass 0 unqualified, then a mask and its inverse
    for (int p = 0; p < 3; p++) begin
      m = (p == 2) ? ~m : $random(seed) & 32'hffff_fff0;
      bus(1, OFS_COND_MASK, m);
      bus(1, OFS_FWD_SELECT, 32'(p > 0));
      q.push_back(m);
      bus(0, OFS_COND_MASK, 0);
      q.push_back(32'(p > 0));
      bus(0, OFS_FWD_SELECT, 0);
      for (int k = 0; k < 32; k++) begin
        e = 32'(p == 0 || m[4*(7-k/4)+3-k%4]) << (k/4);
        q.push_back(e | (32'(e != 0) << 8));
        u_src.look(2'(k), base | k/4);
      end
      // an address held by no entry never hits
      q.push_back(0);
      u_src.look(2'(p), ~base);
    end
    // second reset in mid-run empties the table and the mask
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    q.push_back(0);
    bus(0, OFS_COND_MASK, 0);
    q.push_back(0);
    u_src.look(2'h0, base);
    repeat (4) @(posedge clk);
    report_and_stop;
  end
endmodule // test_celq_top
`default_nettype wire
